// ---- design/pes_exception_sequencer.sv ----
// Exception sequencer: interrupts, traps, privilege and trace
`timescale 1ns/1ps
module pes_exception_sequencer (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // Interrupt request and bus handshake pins
    input  wire logic [2:0]  irq_level_n,
    input  wire logic        transfer_ack_n,
    input  wire logic        bus_error_n,
    input  wire logic        periph_address_valid_n,
    input  wire logic        autovector_request_n,
    input  wire logic [15:0] data_in,
    // Acknowledge cycle outputs
    output logic             address_strobe_n,
    output logic             upper_byte_strobe_n,
    output logic             lower_byte_strobe_n,
    output logic [23:1]      iack_addr,
    // Core instruction events
    input  wire logic        instr_start,
    input  wire logic        instr_decoded,
    input  wire logic [15:0] opcode,
    input  wire logic        instr_done,
    input  wire logic        instr_aborted,
    input  wire logic        overflow,
    input  wire logic        out_of_range,
    input  wire logic        at_boundary,
    input  wire logic [31:0] pc_current,
    input  wire logic [31:0] pc_next,
    input  wire logic [15:0] status_word,
    // Exception request to the core
    output logic             exc_valid,
    output logic [7:0]       exc_vector,
    output logic [23:1]      exc_fetch_addr,
    output logic             exc_fetch_upper,
    output logic [31:0]      exc_stacked_pc,
    output logic [15:0]      exc_stacked_status,
    output logic [15:0]      exc_new_status,
    output logic             exc_short_frame
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [2:0]       ipl_s1;
        logic [2:0]       ipl_s2;
        logic [2:0]       ipl_s3;
        logic [2:0]       lvl;
        logic [2:0]       lvl_prev;
        logic [3:0]       hs_s1;
        logic [3:0]       hs_s2;
        logic [3:0]       hs_s3;
        logic [3:0]       hs;
        logic [7:0]       dat_s1;
        logic [7:0]       dat_s2;
        logic [7:0]       dat_s3;
        logic [7:0]       dat;
        logic             nmi;
        logic             trace_arm;
        logic [15:0]      opcode;
        logic             ins_pend;
        logic [7:0]       ins_vec;
        logic [31:0]      ins_pc;
        logic             trc_pend;
        logic [31:0]      trc_pc;
        logic [2:0]       iack_lvl;
        pes_pkg::pes_seq_t state;
        logic             exc_valid;
        logic [7:0]       exc_vector;
        logic [23:0]      fetch_addr;
        logic [31:0]      stk_pc;
        logic [15:0]      stk_status;
        logic [15:0]      new_status;
        logic             short_frame;
    } pes_regs_t;

    pes_regs_t    st_ff;
    pes_regs_t    nxt_st;
    pes_decode_if dec ();

    // Handshake bit positions in the synchronised group
    localparam int HS_ACK    = 0;
    localparam int HS_AUTO   = 1;
    localparam int HS_PERIPH = 2;
    localparam int HS_ERROR  = 3;

    // Non-interrupt exceptions keep the mask field as it was
    localparam logic [2:0] LEVEL_FILL = pes_pkg::LEVEL_RESET;

    // vector number into bits 9..2, cut to 24 bits
    function automatic logic [23:0] vec_addr(input logic [7:0] v);
        vec_addr = {14'h0000, v, 2'b00};
    endfunction

    // supervisor on, trace off, optional new mask
    function automatic logic [15:0] exc_status(input logic [15:0] sw_in,
                                              input logic        set_mask,
                                              input logic [2:0]  lvl);
        logic [15:0] r;
        r = sw_in;
        r[pes_pkg::STW_SUPER_BIT] = 1'b1;
        r[pes_pkg::STW_TRACE_BIT] = 1'b0;
        if (set_mask) begin
            r[pes_pkg::STW_MASK_LSB +: 3] = lvl;
        end
        exc_status = r;
    endfunction

    logic [2:0] mask;
    logic       int_req;
    logic [7:0] auto_vec;

    assign mask     = status_word[pes_pkg::STW_MASK_LSB +: 3];
    // level 7 at mask 7 is taken only via the nmi latch
    assign int_req  = st_ff.nmi || (st_ff.lvl > mask);
    assign auto_vec = pes_pkg::VEC_AUTO_BASE | {5'h00, st_ff.iack_lvl};

    // ----------------------------------------------------------------
    // Opcode classification
    // ----------------------------------------------------------------
    assign dec.opcode       = instr_decoded ? opcode : st_ff.opcode;
    assign dec.supervisor   = status_word[pes_pkg::STW_SUPER_BIT];
    assign dec.overflow     = overflow;
    assign dec.out_of_range = out_of_range;

    pes_instr_classifier u_cls (
        .dec (dec.cls)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.exc_valid = 1'b0;
        // Pins pass three flops; a change counts once stages 2 and 3 agree
        nxt_st.ipl_s1 = ~irq_level_n;
        nxt_st.ipl_s2 = st_ff.ipl_s1;
        nxt_st.ipl_s3 = st_ff.ipl_s2;
        if (st_ff.ipl_s2 == st_ff.ipl_s3) begin
            nxt_st.lvl = st_ff.ipl_s3;
        end
        nxt_st.hs_s1 = ~{bus_error_n, periph_address_valid_n,
                         autovector_request_n, transfer_ack_n};
        nxt_st.hs_s2 = st_ff.hs_s1;
        nxt_st.hs_s3 = st_ff.hs_s2;
        if (st_ff.hs_s2 == st_ff.hs_s3) begin
            nxt_st.hs = st_ff.hs_s3;
        end
        // only the low data byte carries the vector number
        nxt_st.dat_s1 = data_in[7:0];
        nxt_st.dat_s2 = st_ff.dat_s1;
        nxt_st.dat_s3 = st_ff.dat_s2;
        if (st_ff.dat_s2 == st_ff.dat_s3) begin
            nxt_st.dat = st_ff.dat_s3;
        end
        nxt_st.lvl_prev = st_ff.lvl;

        case (st_ff.state)
            pes_pkg::ST_IDLE: begin
                if (st_ff.ins_pend) begin
                    nxt_st.ins_pend    = 1'b0;
                    nxt_st.exc_valid   = 1'b1;
                    nxt_st.exc_vector  = st_ff.ins_vec;
                    nxt_st.fetch_addr  = vec_addr(st_ff.ins_vec);
                    nxt_st.stk_pc      = st_ff.ins_pc;
                    nxt_st.stk_status  = status_word;
                    nxt_st.new_status  = exc_status(status_word, 1'b0,
                                                    LEVEL_FILL);
                    nxt_st.short_frame = 1'b0;
                end else if (st_ff.trc_pend) begin
                    nxt_st.trc_pend    = 1'b0;
                    nxt_st.exc_valid   = 1'b1;
                    nxt_st.exc_vector  = pes_pkg::VEC_TRACE;
                    nxt_st.fetch_addr  = vec_addr(pes_pkg::VEC_TRACE);
                    nxt_st.stk_pc      = st_ff.trc_pc;
                    nxt_st.stk_status  = status_word;
                    nxt_st.new_status  = exc_status(status_word, 1'b0,
                                                    LEVEL_FILL);
                    nxt_st.short_frame = 1'b0;
                end else if (at_boundary && int_req) begin
                    nxt_st.state    = pes_pkg::ST_IACK;
                    nxt_st.iack_lvl = st_ff.nmi ? pes_pkg::NMI_LEVEL
                                                : st_ff.lvl;
                    nxt_st.nmi      = 1'b0;
                    nxt_st.stk_pc   = pc_next;
                    nxt_st.stk_status = status_word;
                end
            end
            pes_pkg::ST_IACK: begin
                if (st_ff.hs[HS_ERROR]) begin
                    nxt_st.exc_vector  = pes_pkg::VEC_SPURIOUS;
                    nxt_st.fetch_addr  = vec_addr(pes_pkg::VEC_SPURIOUS);
                    nxt_st.short_frame = 1'b1;
                end else if (st_ff.hs[HS_PERIPH] || st_ff.hs[HS_AUTO]) begin
                    nxt_st.exc_vector  = auto_vec;
                    nxt_st.fetch_addr  = vec_addr(auto_vec);
                    nxt_st.short_frame = 1'b0;
                end else begin
                    // any number taken, low 64 not guarded
                    nxt_st.exc_vector  = st_ff.dat;
                    nxt_st.fetch_addr  = vec_addr(st_ff.dat);
                    nxt_st.short_frame = 1'b0;
                end
                if (st_ff.hs != 4'h0) begin
                    nxt_st.exc_valid = 1'b1;
                    nxt_st.new_status = exc_status(st_ff.stk_status, 1'b1,
                                                   st_ff.iack_lvl);
                    nxt_st.state     = pes_pkg::ST_IACK_END;
                end
            end
            pes_pkg::ST_IACK_END: begin
                // Wait for the responder to release before a new cycle
                if (st_ff.hs == 4'h0) begin
                    nxt_st.state = pes_pkg::ST_IDLE;
                end
            end
            default: begin
                nxt_st.state = pes_pkg::ST_IDLE;
            end
        endcase

        // trace bit sampled as the instruction begins
        if (instr_start) begin
            nxt_st.trace_arm = status_word[pes_pkg::STW_TRACE_BIT];
        end
        if (instr_decoded) begin
            nxt_st.opcode = opcode;
            // fault stacks the first word address
            if (dec.priv_fault) begin
                nxt_st.ins_pend  = 1'b1;
                nxt_st.ins_vec   = pes_pkg::VEC_PRIV;
                nxt_st.ins_pc    = pc_current;
                nxt_st.trace_arm = 1'b0;
            end
        end
        if (instr_done && !instr_aborted) begin
            if (dec.cond_trap) begin
                nxt_st.ins_pend = 1'b1;
                nxt_st.ins_vec  = dec.trap_vector;
                nxt_st.ins_pc   = pc_next;
            end
            if (st_ff.trace_arm) begin
                nxt_st.trc_pend = 1'b1;
                nxt_st.trc_pc   = pc_next;
            end
        end
        // each rise to level 7 is a fresh request; set wins
        if (st_ff.lvl == pes_pkg::NMI_LEVEL
            && st_ff.lvl_prev != pes_pkg::NMI_LEVEL) begin
            nxt_st.nmi = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // acknowledge read is a byte on the lower strobe
    assign address_strobe_n    = st_ff.state != pes_pkg::ST_IACK;
    assign lower_byte_strobe_n = st_ff.state != pes_pkg::ST_IACK;
    assign upper_byte_strobe_n = 1'b1;
    assign iack_addr = {pes_pkg::IACK_ADDR_HI, st_ff.iack_lvl};
    assign exc_valid       = st_ff.exc_valid;
    assign exc_vector      = st_ff.exc_vector;
    // entries are four bytes, so address bit 0 is always zero
    assign exc_fetch_addr  = st_ff.fetch_addr[23:1];
    assign exc_fetch_upper = ~st_ff.fetch_addr[0];
    assign exc_stacked_pc  = st_ff.stk_pc;
    assign exc_stacked_status = st_ff.stk_status;
    assign exc_new_status     = st_ff.new_status;
    assign exc_short_frame = st_ff.short_frame;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_iack_error;
        st_ff.state == pes_pkg::ST_IACK && st_ff.hs[HS_ERROR];
    endsequence
    sequence s_iack_auto;
        st_ff.state == pes_pkg::ST_IACK && !st_ff.hs[HS_ERROR]
        && (st_ff.hs[HS_PERIPH] || st_ff.hs[HS_AUTO]);
    endsequence

    chk_vec_addr_form: assert property (
        exc_valid |-> st_ff.fetch_addr == vec_addr(exc_vector))
        else $error("vector address not formed from vector");
    chk_nmi_edge_set: assert property (
        (st_ff.lvl == 3'h7 && st_ff.lvl_prev != 3'h7) |=> st_ff.nmi
        || st_ff.state == pes_pkg::ST_IACK)
        else $error("rise to level 7 lost");
    chk_mask_gate: assert property (
        (st_ff.state == pes_pkg::ST_IDLE
         && $past(st_ff.state) == pes_pkg::ST_IDLE) ##1
        st_ff.state == pes_pkg::ST_IACK |->
        ($past(st_ff.lvl) > $past(mask)) || $past(st_ff.nmi))
        else $error("interrupt taken at or below mask");
    chk_spurious: assert property (
        s_iack_error |=> exc_valid && exc_vector == 8'h18
        && exc_short_frame)
        else $error("bus error in acknowledge not spurious");
    chk_auto_vector: assert property (
        s_iack_auto |=> exc_valid
        && exc_vector == 8'h18 + {5'h00, $past(st_ff.iack_lvl)})
        else $error("autovector number wrong");
    chk_priv_pc: assert property (
        (instr_decoded && dec.priv_fault) |=> st_ff.ins_pend
        && st_ff.ins_vec == 8'h08 && st_ff.ins_pc == $past(pc_current))
        else $error("privilege fault not recorded");
    chk_new_status_bits: assert property (
        exc_valid |-> exc_new_status[15] == 1'b0 && exc_new_status[13])
        else $error("exception status word wrong");
    chk_no_abort_trace: assert property (
        (instr_done && instr_aborted && !st_ff.trc_pend) |=>
        !st_ff.trc_pend)
        else $error("trace raised for aborted instruction");
    chk_order_ins_first: assert property (
        (st_ff.state == pes_pkg::ST_IDLE && st_ff.ins_pend
         && st_ff.trc_pend) |=> exc_valid && exc_vector != 8'h09
        && st_ff.trc_pend)
        else $error("trace ahead of instruction exception");
    chk_iack_strobes: assert property (
        !address_strobe_n |-> upper_byte_strobe_n
        && !lower_byte_strobe_n)
        else $error("acknowledge strobe choice wrong");
endmodule

// ---- design/pes_instr_classifier.sv ----
// Opcode classifier: privilege faults and instruction traps
`timescale 1ns/1ps
module pes_instr_classifier (
    pes_decode_if.cls dec
);
    logic is_priv;
    logic is_trap;
    logic is_ovf;
    logic is_bounds;

    always_comb begin
        is_priv = (dec.opcode == pes_pkg::OP_OR_STATUS)
               || (dec.opcode == pes_pkg::OP_AND_STATUS)
               || (dec.opcode == pes_pkg::OP_XOR_STATUS)
               || ((dec.opcode & pes_pkg::OP_USTK_MASK)
                   == pes_pkg::OP_USTK_MOVE)
               || (dec.opcode == pes_pkg::OP_RESET)
               || (dec.opcode == pes_pkg::OP_STOP)
               || (dec.opcode == pes_pkg::OP_EXC_RETURN);
        is_trap   = (dec.opcode & pes_pkg::OP_TRAP_MASK)
                    == pes_pkg::OP_TRAP;
        is_ovf    = dec.opcode == pes_pkg::OP_OVF_TRAP;
        is_bounds = (dec.opcode & pes_pkg::OP_BOUNDS_MASK)
                    == pes_pkg::OP_BOUNDS;
        dec.priv_fault = is_priv && !dec.supervisor;
        dec.cond_trap = is_trap || (is_ovf && dec.overflow)
                     || (is_bounds && dec.out_of_range);
        if (is_trap) begin
            dec.trap_vector = pes_pkg::VEC_TRAP_BASE
                            | {4'h0, dec.opcode[3:0]};
        end else if (is_ovf) begin
            dec.trap_vector = pes_pkg::VEC_OVF_TRAP;
        end else begin
            dec.trap_vector = pes_pkg::VEC_BOUNDS;
        end
    end
endmodule

// ---- inc/pes_decode_if.sv ----
// Opcode classification carrier between sequencer and classifier
`timescale 1ns/1ps
interface pes_decode_if;
    logic [15:0] opcode;
    logic        supervisor;
    logic        overflow;
    logic        out_of_range;
    logic        priv_fault;
    logic        cond_trap;
    logic [7:0]  trap_vector;

    modport seq (
        output opcode,
        output supervisor,
        output overflow,
        output out_of_range,
        input  priv_fault,
        input  cond_trap,
        input  trap_vector
    );
    modport cls (
        input  opcode,
        input  supervisor,
        input  overflow,
        input  out_of_range,
        output priv_fault,
        output cond_trap,
        output trap_vector
    );
endinterface

// ---- inc/pes_pkg.sv ----
// Shared constants and types for the exception sequencer
package pes_pkg;

    // ----------------------------------------------------------------
    // Status word layout and reset values
    // ----------------------------------------------------------------
    localparam int        STW_TRACE_BIT = 15;
    localparam int        STW_SUPER_BIT = 13;
    localparam int        STW_MASK_LSB  = 8;
    localparam logic [2:0] LEVEL_RESET  = 3'h0;
    localparam logic [2:0] NMI_LEVEL    = 3'h7;

    // ----------------------------------------------------------------
    // Vector table
    // ----------------------------------------------------------------
    localparam int         VEC_TABLE_BYTES = 1024;
    localparam int         VEC_TABLE_WORDS = 512;
    localparam int         VEC_ENTRY_BYTES = 4;
    localparam int         VEC_COUNT       = 255;
    localparam int         VEC_USER_COUNT  = 192;
    localparam int         VEC_UNPROTECTED = 64;
    localparam int         BUS_ADDR_BITS   = 24;
    localparam logic [7:0] VEC_BOUNDS      = 8'h06;
    localparam logic [7:0] VEC_OVF_TRAP    = 8'h07;
    localparam logic [7:0] VEC_PRIV        = 8'h08;
    localparam logic [7:0] VEC_TRACE       = 8'h09;
    localparam logic [7:0] VEC_UNINIT      = 8'h0F;
    localparam logic [7:0] VEC_SPURIOUS    = 8'h18;
    localparam logic [7:0] VEC_AUTO_BASE   = 8'h18;
    localparam logic [7:0] VEC_TRAP_BASE   = 8'h20;

    // ----------------------------------------------------------------
    // Acknowledge cycle address, upper bits
    // ----------------------------------------------------------------
    localparam logic [19:0] IACK_ADDR_HI   = 20'hFFFFF;

    // ----------------------------------------------------------------
    // Opcode patterns
    // ----------------------------------------------------------------
    localparam logic [15:0] OP_OR_STATUS   = 16'h007C;
    localparam logic [15:0] OP_AND_STATUS  = 16'h027C;
    localparam logic [15:0] OP_XOR_STATUS  = 16'h0A7C;
    localparam logic [15:0] OP_USTK_MASK   = 16'hFFF0;
    localparam logic [15:0] OP_USTK_MOVE   = 16'h4E60;
    localparam logic [15:0] OP_RESET       = 16'h4E70;
    localparam logic [15:0] OP_STOP        = 16'h4E72;
    localparam logic [15:0] OP_EXC_RETURN  = 16'h4E73;
    localparam logic [15:0] OP_OVF_TRAP    = 16'h4E76;
    localparam logic [15:0] OP_TRAP_MASK   = 16'hFFF0;
    localparam logic [15:0] OP_TRAP        = 16'h4E40;
    localparam logic [15:0] OP_BOUNDS_MASK = 16'hF1C0;
    localparam logic [15:0] OP_BOUNDS      = 16'h4180;

    // ----------------------------------------------------------------
    // Sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_IACK,
        ST_IACK_END
    } pes_seq_t;

endpackage

// ---- tb/pes_irq_responder.sv ----
// Far-side responder model for acknowledge cycles
`timescale 1ns/1ps
module pes_irq_responder (
    // Strobe side
    input  wire logic        clk,
    input  wire logic        address_strobe_n,
    // Answer kind: 0 ack, 1 periph, 2 error, 3 auto
    input  wire logic [1:0]  mode,
    input  wire logic [1:0]  dly,
    input  wire logic [7:0]  vec,
    // Answers {ack, periph, error, auto}
    output logic [3:0]       resp_n,
    output logic [15:0]      data_in
);
    logic [1:0] cnt_ff = 2'h0;
    initial {resp_n, data_in} = {4'hF, 16'h0};
    always @(posedge clk) begin
        cnt_ff <= address_strobe_n ? 2'h0 : cnt_ff + 2'(cnt_ff < dly);
        // vector on low byte, junk above
        data_in <= address_strobe_n ? ~data_in : {~vec, vec};
        resp_n <= (address_strobe_n || cnt_ff < dly) ? 4'hF
                                                     : ~(4'h8 >> mode);
    end
endmodule

// ---- tb/tb_processor_exception_sequencer.sv ----
// Self-checking bench for the exception sequencer
`timescale 1ns/1ps
module tb_processor_exception_sequencer;
    logic        clk = 0, reset = 1, start = 0, dec = 0, done = 0;
    logic        abrt = 0, bnd = 0, astb_n, ustb_n, lstb_n, ev, efu, esf;
    logic [1:0]  mode = 0, dly = 1, f = 0;
    logic [2:0]  irq_n = 3'h7;
    logic [3:0]  rsp;
    logic [7:0]  vec = 0, evec;
    logic [15:0] op = 0, sw = 0, din, esr, nsr;
    logic [23:1] efa, iaddr, iack_exp = 23'h0;
    logic [31:0] pcc = 0, pcn = 0, epc, rng = 32'h0000A42B;
    logic [96:0] q[$];
    int          n_fail = 0, tests_run = 0;
    pes_exception_sequencer uut (.clk(clk), .reset(reset),
        .irq_level_n(irq_n), .transfer_ack_n(rsp[3]), .bus_error_n(rsp[1]),
        .periph_address_valid_n(rsp[2]), .autovector_request_n(rsp[0]),
        .data_in(din), .address_strobe_n(astb_n),
        .upper_byte_strobe_n(ustb_n), .lower_byte_strobe_n(lstb_n),
        .iack_addr(iaddr), .instr_start(start),
        .instr_decoded(dec), .opcode(op), .instr_done(done),
        .instr_aborted(abrt), .overflow(f[1]), .out_of_range(f[0]),
        .at_boundary(bnd), .pc_current(pcc), .pc_next(pcn),
        .status_word(sw), .exc_valid(ev), .exc_vector(evec),
        .exc_fetch_addr(efa), .exc_fetch_upper(efu), .exc_stacked_pc(epc),
        .exc_stacked_status(esr), .exc_new_status(nsr),
        .exc_short_frame(esf));
    pes_irq_responder far (.clk(clk), .address_strobe_n(astb_n), .mode(mode),
        .dly(dly), .vec(vec), .resp_n(rsp), .data_in(din));
    initial forever #12.5 clk = ~clk;
    initial begin
        #1000000 n_fail++;
        finish_test();
    end
    function automatic logic [31:0] rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction
    // Record: vector, fetch address, lane, pc, old sr, new sr, frame
    function automatic logic [96:0] rec(input logic [7:0] v,
        input logic [31:0] pc, input logic sf, input logic [3:0] l);
        logic [15:0] n;
        n = (sw | 16'h2000) & 16'h7FFF;
        if (l[3]) n[10:8] = l[2:0];
        return {v, 14'h0, v, 1'b0, 1'b1, pc, sw, n, sf};
    endfunction
    task automatic check(input logic [96:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %h vs %h", $time, seen, exp);
        end
    endtask
    task automatic expect_exc(input logic [96:0] e);
        for (int i = 0; i < 60 && q.size() == 0; i++) @(posedge clk);
        check(q.size() > 0 ? q.pop_front() : ~e, e);
    endtask
    task automatic quiet(input int n);
        repeat (n) @(posedge clk);
        check(97'(q.size()), 97'h0);
    endtask
    task automatic instr(input logic [15:0] o, s, input logic [1:0] c,
        input logic d, a);
        @(posedge clk) #2 {sw, start} = {s, 1'b1};
        @(posedge clk) #2 {start, dec, op, pcc} = {2'b01, o, rnd()};
        @(posedge clk) #2 {dec, done, abrt, f, pcn} = {1'b0, d, a, c, rnd()};
        @(posedge clk) #2 {done, abrt} = 2'b00;
    endtask
    task automatic irq(input logic [2:0] l, m, input logic [1:0] md,
        input logic [7:0] v, x, input logic sf, take, rel);
        @(posedge clk) #2 {sw, mode, vec, dly, irq_n, bnd, pcn} = {5'h04, m,
            8'h00, md, v, 2'(rnd() % 3 + 1), ~l, 1'b1, rnd()};
        iack_exp = {pes_pkg::IACK_ADDR_HI, l};
        if (take) expect_exc(rec(x, pcn, sf, {1'b1, l}));
        else quiet(40);
        @(posedge clk) #2 {irq_n, bnd} = {rel ? 3'h7 : irq_n, 1'b0};
        repeat (12) @(posedge clk);
    endtask
    task automatic finish_test();
        $display("checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clk) begin
        #1;
        if (ev === 1'b1) q.push_back({evec, efa, efu, epc, esr, nsr, esf});
        if (astb_n === 1'b0) check(97'({ustb_n, lstb_n}), 97'h2);
        if (astb_n === 1'b0) check(97'(iaddr), 97'(iack_exp));
    end
    initial begin
        logic [15:0] pv [7];
        logic [7:0] v;
        logic [2:0] l;
        pv = '{pes_pkg::OP_OR_STATUS, pes_pkg::OP_AND_STATUS,
            pes_pkg::OP_XOR_STATUS, pes_pkg::OP_USTK_MOVE, pes_pkg::OP_RESET,
            pes_pkg::OP_STOP, pes_pkg::OP_EXC_RETURN};
        repeat (8) @(posedge clk);
        #2 reset = 0;
        repeat (4) begin
            v = 8'(rnd() % 16);
            instr(pes_pkg::OP_TRAP | 16'(v), 16'h8000, 2'b00, 1, 0);
            expect_exc(rec(pes_pkg::VEC_TRAP_BASE + v, pcn, 0, 0));
            expect_exc(rec(pes_pkg::VEC_TRACE, pcn, 0, 0));
        end
        for (int k = 0; k < 4; k++) begin
            instr(k[1] ? pes_pkg::OP_BOUNDS : pes_pkg::OP_OVF_TRAP, 16'h0000,
                k[1] ? {~k[0], k[0]} : {k[0], ~k[0]}, 1, 0);
            if (k[0]) expect_exc(rec(k[1] ? pes_pkg::VEC_BOUNDS
                : pes_pkg::VEC_OVF_TRAP, pcn, 0, 0));
            else quiet(8);
        end
        instr(pes_pkg::OP_TRAP, 16'h8000, 2'b00, 1, 1);
        quiet(10);
        foreach (pv[i]) begin
            instr(pv[i], 16'h8000, 2'b00, 0, 0);
            expect_exc(rec(pes_pkg::VEC_PRIV, pcc, 0, 0));
            quiet(8);
        end
        instr(pes_pkg::OP_EXC_RETURN, 16'h2000, 2'b00, 1, 0);
        quiet(8);
        repeat (3) begin
            l = 3'(rnd() % 6 + 1);
            v = 8'(rnd());
            irq(l, l - 3'h1, 0, v, v, 0, 1, 1);
            irq(l, l, 0, v, v, 0, 0, 1);
        end
        irq(2, 0, 0, 15, pes_pkg::VEC_UNINIT, 0, 1, 1);
        for (int k = 1; k < 4; k++)
            irq(5, 4, 2'(k), 8'h33, k == 2 ? pes_pkg::VEC_SPURIOUS
                : pes_pkg::VEC_AUTO_BASE + 8'h05, k == 2, 1, 1);
        irq(7, 7, 0, v, v, 0, 1, 0);
        irq(7, 7, 0, v, v, 0, 0, 0);
        irq(7, 6, 0, v, v, 0, 1, 1);
        finish_test();
    end
endmodule
